// ==== rtl/nmi_ports_pkg.sv ====
// constants for the legacy system control port block
// assumes a 100 MHz bridge clock and 16-bit i/o port addresses
package nmi_ports_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned DATA_W        = 8;
  // port addresses
  localparam logic [15:0] MOUSE_IRQ_RELEASE_ADDR     = 16'h0060;
  localparam logic [15:0] NMI_STATUS_CONTROL_ADDR    = 16'h0061;
  localparam logic [15:0] NMI_MASK_CLOCK_INDEX_ADDR  = 16'h0070;
  localparam logic [15:0] FAST_GATE_RESET_PORT_ADDR  = 16'h0092;
  localparam logic [15:0] FLOPPY_OUTPUT_PRIMARY_ADDR = 16'h03f2;
  localparam logic [15:0] FLOPPY_OUTPUT_SECOND_ADDR  = 16'h0372;
  // status/control field positions
  localparam int unsigned SC_SERR_ST_BIT  = 7;
  localparam int unsigned SC_IOCHK_ST_BIT = 6;
  localparam int unsigned SC_CNT2_OUT_BIT = 5;
  localparam int unsigned SC_REFRESH_BIT  = 4;
  localparam int unsigned SC_IOCHK_DIS_BIT = 3;
  localparam int unsigned SC_SERR_DIS_BIT = 2;
  localparam int unsigned SC_SPK_EN_BIT   = 1;
  localparam int unsigned SC_GATE2_BIT    = 0;
  localparam logic [3:0]  SC_CTRL_RESET   = 4'h0;
  // mask port fields
  localparam int unsigned MASK_BIT        = 7;
  localparam logic        MASK_RESET      = 1'b1;
  localparam logic [6:0]  CLK_INDEX_RESET = 7'h00;
  // fast gate / reset port
  localparam logic [7:0]  FGR_RESET       = 8'h24;
  localparam logic [7:0]  FGR_FIXED_MASK  = 8'hfc;
  localparam int unsigned FGR_A20_BIT     = 1;
  localparam int unsigned FGR_RST_BIT     = 0;
  // floppy output field
  localparam int unsigned FOC_DMA_EN_BIT  = 3;
  localparam logic        FOC_DMA_EN_RESET = 1'b0;
  // alternate reset pulse: four isa clocks of 120 ns
  localparam int unsigned ALT_CPU_RESET_N_NS      = 480;
  localparam int unsigned ALT_CPU_RESET_N_CYCLES  =
    (ALT_CPU_RESET_N_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ALT_CPU_RESET_N_CNT_W   = 6;
  // pins that pass the synchroniser
  localparam int unsigned SYNC_W          = 4;
  localparam int unsigned SYNC_SERR       = 0;
  localparam int unsigned SYNC_IOCHK      = 1;
  localparam int unsigned SYNC_MOUSE      = 2;
  localparam int unsigned SYNC_DACK2      = 3;
endpackage

// ==== rtl/pin_sync.sv ====
// two flop synchroniser, one per pin
// assumes pins are asynchronous to clock_i; reset value is a parameter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned     WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      // first stage feeds only the second
      always_ff @(posedge clock_i)
      begin
        if (!rst_b_i)
        begin
          meta_r[g] <= INIT[g];
          sync_o[g] <= INIT[g];
        end
        else
        begin
          meta_r[g] <= pin_i[g];
          sync_o[g] <= meta_r[g];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ==== rtl/alt_reset_pulse.sv ====
// low-going reset pulse of fixed length, started by a one-cycle fire
// assumes fire_i is a same-clock pulse; a fire during a pulse is dropped, except in its last low cycle, where it restarts the pulse
`timescale 1ns/1ps
`default_nettype none
module alt_reset_pulse
  import nmi_ports_pkg::*;
#(
  parameter int unsigned CYCLES = nmi_ports_pkg::ALT_CPU_RESET_N_CYCLES
) (
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  input  wire logic fire_i,
  output logic      reset_n_o
);
  // cycles from the eighth low sample to the first high one
  localparam int PULSE_TAIL = int'(CYCLES) - 7;
  logic [ALT_CPU_RESET_N_CNT_W-1:0] cnt_r;

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      cnt_r     <= '0;
      reset_n_o <= 1'b1;
    end
    else if (fire_i && cnt_r == '0)
    begin
      cnt_r     <= ALT_CPU_RESET_N_CNT_W'(CYCLES - 1);
      reset_n_o <= 1'b0;
    end
    else if (cnt_r != '0)
    begin
      cnt_r <= cnt_r - ALT_CPU_RESET_N_CNT_W'(1);
    end
    else
    begin
      reset_n_o <= 1'b1;
    end
  end

  a_pulse_len: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $fell(reset_n_o) |-> !reset_n_o [*8] ##PULSE_TAIL reset_n_o)
    else $error("alternate reset pulse has wrong length");
endmodule
`default_nettype wire

// ==== rtl/system_nmi_control_ports.sv ====
// legacy system control i/o ports: nmi sources and mask, speaker gate,
// refresh toggle, fast a20 and cpu reset, floppy dma gate, mouse irq.
// assumes one-cycle io_rd_i/io_wr_i strobes with a stable address,
// counter 2 and refresh events come from same-clock logic.
//
// Behaviour
// - serr pulse sets read-only status bit 7
// - bit 2: 0 enables serr, 1 clears
// - iochk assertion sets read-only status bit 6
// - bit 3: 0 enables iochk, 1 clears
// - bit 5 reads live counter 2 output
// - bit 4 toggles per refresh, resets 0
// - speaker is bit 1 and counter 2 output
// - bit 0 drives counter 2 gate
// - mask bit 7 blocks all nmi, resets 1
// - mask write also loads clock index bits
// - fast port only when enabled, forwarded
// - fast port fixed bits read 24h pattern
// - bit 1 drives a20 override level
// - writing bit 0 from 0 to 1 pulses cpu reset low
// - floppy bit 3 lets dack2 enable xcvr
// - enabled: port 60h read releases mouse irq
// - disabled: port 60h read is only forwarded to isa
// - enabled mouse irq routed out as irq13
// - mask port accesses forwarded to isa
`timescale 1ns/1ps
`default_nettype none
module system_nmi_control_ports
  import nmi_ports_pkg::*;
#(
  parameter int unsigned ALT_CYCLES = nmi_ports_pkg::ALT_CPU_RESET_N_CYCLES
) (
  input  wire logic                           clock_i,
  input  wire logic                           rst_b_i,
  input  wire logic [nmi_ports_pkg::ADDR_W-1:0] io_addr_i,
  input  wire logic                           io_rd_i,
  input  wire logic                           io_wr_i,
  input  wire logic [nmi_ports_pkg::DATA_W-1:0] io_wdata_i,
  output logic      [nmi_ports_pkg::DATA_W-1:0] io_rdata_o,
  output logic                                io_rvalid_o,
  output logic                                isa_forward_o,
  input  wire logic                           serr_n_i,
  input  wire logic                           iochk_n_i,
  input  wire logic                           mouse_irq_in_i,
  input  wire logic                           dack2_n_i,
  input  wire logic                           fast_port_en_i,
  input  wire logic                           mouse_fn_en_i,
  input  wire logic                           counter2_out_i,
  input  wire logic                           refresh_done_i,
  output logic                                counter2_gate_o,
  output logic                                speaker_out_o,
  output logic                                nmi_o,
  output logic                                a20_override_o,
  output logic                                alt_cpu_reset_n_o,
  output logic                                utility_xcvr_oe_n_o,
  output logic                                irq13_o,
  output logic      [6:0]                     clock_index_o
);
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_s;
  logic              serr_n_s;
  logic              serr_n_d_r;
  logic              iochk_n_s;
  logic              mouse_s;
  logic              mouse_d_r;
  logic              dack2_n_s;
  logic              serr_event;
  logic              mouse_event;
  logic              hit_release;
  logic              hit_sc;
  logic              hit_mask;
  logic              hit_fast;
  logic              hit_floppy;
  logic              wr_sc;
  logic              wr_mask;
  logic              wr_fast;
  logic              rd_release;
  logic              serr_st_r;
  logic              iochk_st_r;
  logic              refresh_tgl_r;
  logic [3:0]        sc_ctrl_r;
  logic              mask_r;
  logic [6:0]        clk_index_r;
  logic              a20_r;
  logic              rst_bit_r;
  logic              fire;
  logic              floppy_dma_en_r;
  logic              mouse_latch_r;
  logic [7:0]        rdata_nxt;
  logic              rvalid_nxt;

  assign pins_raw[SYNC_SERR]  = serr_n_i;
  assign pins_raw[SYNC_IOCHK] = iochk_n_i;
  assign pins_raw[SYNC_MOUSE] = mouse_irq_in_i;
  assign pins_raw[SYNC_DACK2] = dack2_n_i;

  // idle levels as reset values avoid false events after reset
  pin_sync #(
    .WIDTH (SYNC_W),
    .INIT  (4'hb)
  ) u_sync (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .pin_i   (pins_raw),
    .sync_o  (pins_s)
  );

  assign serr_n_s  = pins_s[SYNC_SERR];
  assign iochk_n_s = pins_s[SYNC_IOCHK];
  assign mouse_s   = pins_s[SYNC_MOUSE];
  assign dack2_n_s = pins_s[SYNC_DACK2];

  // address decode
  assign hit_release = io_addr_i == MOUSE_IRQ_RELEASE_ADDR;
  assign hit_sc      = io_addr_i == NMI_STATUS_CONTROL_ADDR;
  assign hit_mask    = io_addr_i == NMI_MASK_CLOCK_INDEX_ADDR;
  assign hit_fast    = (io_addr_i == FAST_GATE_RESET_PORT_ADDR) && fast_port_en_i;
  assign hit_floppy  = (io_addr_i == FLOPPY_OUTPUT_PRIMARY_ADDR) ||
                       (io_addr_i == FLOPPY_OUTPUT_SECOND_ADDR);
  assign wr_sc       = io_wr_i && hit_sc;
  assign wr_mask     = io_wr_i && hit_mask;
  assign wr_fast     = io_wr_i && hit_fast;
  assign rd_release  = io_rd_i && hit_release;

  assign isa_forward_o = (io_rd_i || io_wr_i) &&
                         (hit_mask || hit_fast || hit_floppy || hit_release);

  // edge detect on synchronised levels only
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      serr_n_d_r <= 1'b1;
      mouse_d_r  <= 1'b0;
    end
    else
    begin
      serr_n_d_r <= serr_n_s;
      mouse_d_r  <= mouse_s;
    end
  end

  assign serr_event  = serr_n_d_r && !serr_n_s;
  assign mouse_event = mouse_s && !mouse_d_r;

  // serr status; disable bit holds it clear
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      serr_st_r <= 1'b0;
    else if (sc_ctrl_r[SC_SERR_DIS_BIT])
      serr_st_r <= 1'b0;
    else if (serr_event)
      serr_st_r <= 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      iochk_st_r <= 1'b0;
    else if (sc_ctrl_r[SC_IOCHK_DIS_BIT])
      iochk_st_r <= 1'b0;
    else if (!iochk_n_s)
      iochk_st_r <= 1'b1;
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      refresh_tgl_r <= 1'b0;
    else if (refresh_done_i)
      refresh_tgl_r <= !refresh_tgl_r;
  end

  // upper bits are read-only, writes to them are dropped
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      sc_ctrl_r <= SC_CTRL_RESET;
    else if (wr_sc)
      sc_ctrl_r <= io_wdata_i[3:0];
  end

  assign counter2_gate_o = sc_ctrl_r[SC_GATE2_BIT];
  assign speaker_out_o   = sc_ctrl_r[SC_SPK_EN_BIT] && counter2_out_i;

  // mask and clock index loaded together
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      mask_r      <= MASK_RESET;
      clk_index_r <= CLK_INDEX_RESET;
    end
    else if (wr_mask)
    begin
      mask_r      <= io_wdata_i[MASK_BIT];
      clk_index_r <= io_wdata_i[6:0];
    end
  end

  assign clock_index_o = clk_index_r;

  // nmi output; status bits are cleared when their source is off
  assign nmi_o = !mask_r && (serr_st_r || iochk_st_r);

  // fast port bits; fire only on a 0 to 1 of bit 0
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      a20_r     <= FGR_RESET[FGR_A20_BIT];
      rst_bit_r <= FGR_RESET[FGR_RST_BIT];
    end
    else if (wr_fast)
    begin
      a20_r     <= io_wdata_i[FGR_A20_BIT];
      rst_bit_r <= io_wdata_i[FGR_RST_BIT];
    end
  end

  assign fire           = wr_fast && io_wdata_i[FGR_RST_BIT] && !rst_bit_r;
  assign a20_override_o = a20_r;

  alt_reset_pulse #(
    .CYCLES (ALT_CYCLES)
  ) u_alt_cpu_reset_n (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .fire_i    (fire),
    .reset_n_o (alt_cpu_reset_n_o)
  );

  // floppy dma gate of the transceiver enable
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      floppy_dma_en_r <= FOC_DMA_EN_RESET;
    else if (io_wr_i && hit_floppy)
      floppy_dma_en_r <= io_wdata_i[FOC_DMA_EN_BIT];
  end

  assign utility_xcvr_oe_n_o = !(floppy_dma_en_r && !dack2_n_s);

  // mouse latch; a new edge wins over a release
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      mouse_latch_r <= 1'b0;
    else if (!mouse_fn_en_i)
      mouse_latch_r <= 1'b0;
    else if (mouse_event)
      mouse_latch_r <= 1'b1;
    else if (rd_release)
      mouse_latch_r <= 1'b0;
  end

  assign irq13_o = mouse_fn_en_i && mouse_latch_r;

  // read mux; mask and floppy ports are write only, 60h data is the isa
  always_comb
  begin
    rdata_nxt  = 8'h00;
    rvalid_nxt = 1'b0;
    if (io_rd_i && hit_sc)
    begin
      rdata_nxt  = {serr_st_r, iochk_st_r, counter2_out_i, refresh_tgl_r,
                    sc_ctrl_r};
      rvalid_nxt = 1'b1;
    end
    else if (io_rd_i && hit_fast)
    begin
      rdata_nxt  = (FGR_RESET & FGR_FIXED_MASK) | {6'h00, a20_r, rst_bit_r};
      rvalid_nxt = 1'b1;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      io_rdata_o  <= 8'h00;
      io_rvalid_o <= 1'b0;
    end
    else
    begin
      io_rdata_o  <= rdata_nxt;
      io_rvalid_o <= rvalid_nxt;
    end
  end

  sequence s_fast_fire;
    wr_fast && io_wdata_i[FGR_RST_BIT] && !rst_bit_r;
  endsequence

  sequence s_rst_low;
    !alt_cpu_reset_n_o;
  endsequence

  a_serr_sets: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    serr_event && !sc_ctrl_r[SC_SERR_DIS_BIT] |=> serr_st_r)
    else $error("serr event did not set status");

  a_serr_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    sc_ctrl_r[SC_SERR_DIS_BIT] |=> !serr_st_r)
    else $error("serr status not cleared while disabled");

  a_iochk_sets: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !iochk_n_s && !sc_ctrl_r[SC_IOCHK_DIS_BIT] |=> iochk_st_r)
    else $error("iochk level did not set status");

  a_iochk_clear: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    sc_ctrl_r[SC_IOCHK_DIS_BIT] |=> !iochk_st_r)
    else $error("iochk status not cleared while disabled");

  a_refresh_tgl: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    refresh_done_i |=> refresh_tgl_r != $past(refresh_tgl_r))
    else $error("refresh bit did not toggle");

  a_speaker_gate: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    speaker_out_o == (sc_ctrl_r[SC_SPK_EN_BIT] && counter2_out_i))
    else $error("speaker output not gated by enable");

  a_mask_load: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    wr_mask |=> mask_r == $past(io_wdata_i[MASK_BIT]) &&
                clock_index_o == $past(io_wdata_i[6:0]))
    else $error("mask port write not taken");

  a_nmi_masked: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    nmi_o == (!mask_r && (serr_st_r || iochk_st_r)))
    else $error("nmi output disagrees with mask and status");

  a_fast_pulse: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    s_fast_fire |=> s_rst_low [*4])
    else $error("fast reset write gave no pulse");

  a_no_rearm: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    wr_fast && rst_bit_r && alt_cpu_reset_n_o |=> alt_cpu_reset_n_o)
    else $error("reset pulse without re-arm");

  a_fast_gated: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    io_rd_i && !fast_port_en_i && io_addr_i == FAST_GATE_RESET_PORT_ADDR |=> !io_rvalid_o)
    else $error("fast port answered while disabled");

  a_mouse_rel: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    rd_release && mouse_fn_en_i && !mouse_event |=> !mouse_latch_r)
    else $error("port 60h read did not release mouse irq");

  a_mouse_route: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    mouse_event && mouse_fn_en_i ##1 mouse_fn_en_i |-> irq13_o)
    else $error("mouse irq not routed");

  a_floppy_oe: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !floppy_dma_en_r |-> utility_xcvr_oe_n_o)
    else $error("transceiver enabled with dma gate off");
endmodule
`default_nettype wire

// ==== testbench/io_host_model.sv ====
// host model: issues one-cycle i/o read and write strobes to the ports
// assumes the bench calls its tasks from one process; clock from the bench
`timescale 1ns/1ps
`default_nettype none
module io_host_model (
  input  wire logic        clock_i,
  input  wire logic [7:0]  io_rdata_i,
  input  wire logic        io_rvalid_i,
  input  wire logic        isa_forward_i,
  output logic      [15:0] io_addr_o,
  output logic             io_rd_o,
  output logic             io_wr_o,
  output logic      [7:0]  io_wdata_o
);
  initial
  begin
    io_addr_o  = 16'hffff;
    io_rd_o    = 1'b0;
    io_wr_o    = 1'b0;
    io_wdata_o = 8'h00;
  end

  // one strobe, held to the taking edge; released lines never keep old values
  task automatic cycle(input logic [15:0] a, input logic w, input logic [7:0] d,
                       output logic f);
    @(posedge clock_i);
    #1;
    io_addr_o  = a;
    io_wdata_o = d;
    io_wr_o    = w;
    io_rd_o    = !w;
    #1;
    f = isa_forward_i;
    @(posedge clock_i);
    #1;
    io_wr_o    = 1'b0;
    io_rd_o    = 1'b0;
    io_addr_o  = ~a;
    io_wdata_o = ~d;
  endtask

  task automatic io_write(input logic [15:0] a, input logic [7:0] d, output logic f);
    logic [7:0] v;
    v = d;
    if (a == 16'h0061)
      v = d & 8'h0f;
    cycle(a, 1'b1, v, f);
  endtask

  // read data is registered, so it is taken just after the taking edge
  task automatic io_read(input logic [15:0] a, output logic [7:0] d, output logic v,
                         output logic f);
    cycle(a, 1'b0, 8'h00, f);
    d = io_rdata_i;
    v = io_rvalid_i;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb_system_nmi_control_ports.sv ====
// self-checking bench for the system control port block
// assumes the host model owns the i/o strobes; pins are driven here
`timescale 1ns/1ps
`default_nettype none
module tb_system_nmi_control_ports;
  import nmi_ports_pkg::*;
  // short pulse keeps the run brief
  localparam int unsigned ALT = 10;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, rdat;
  logic        io_rd, io_wr, io_rvalid, isa_fwd, rval, fwd;
  logic        serr_n = 1'b1, iochk_n = 1'b1, mouse_in = 1'b0, dack2_n = 1'b1;
  logic        fast_en = 1'b1, mouse_en = 1'b0, cnt2 = 1'b0, refr = 1'b0;
  logic        gate, spk, nmi, a20, alt_n, oe_n, irq13;
  logic [6:0]  cidx;
  int          bad_count = 0;
  int          samples_checked = 0;

  always #(CLK_PERIOD_NS / 2) clock_i = ~clock_i;

  system_nmi_control_ports #(.ALT_CYCLES(ALT)) i_system_nmi_control_ports (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .io_addr_i(io_addr), .io_rd_i(io_rd),
    .io_wr_i(io_wr), .io_wdata_i(io_wdata), .io_rdata_o(io_rdata),
    .io_rvalid_o(io_rvalid), .isa_forward_o(isa_fwd), .serr_n_i(serr_n),
    .iochk_n_i(iochk_n), .mouse_irq_in_i(mouse_in), .dack2_n_i(dack2_n),
    .fast_port_en_i(fast_en), .mouse_fn_en_i(mouse_en), .counter2_out_i(cnt2),
    .refresh_done_i(refr), .counter2_gate_o(gate), .speaker_out_o(spk),
    .nmi_o(nmi), .a20_override_o(a20), .alt_cpu_reset_n_o(alt_n),
    .utility_xcvr_oe_n_o(oe_n), .irq13_o(irq13), .clock_index_o(cidx));

  io_host_model i_io_host_model (
    .clock_i(clock_i), .io_rdata_i(io_rdata), .io_rvalid_i(io_rvalid),
    .isa_forward_i(isa_fwd), .io_addr_o(io_addr), .io_rd_o(io_rd),
    .io_wr_o(io_wr), .io_wdata_o(io_wdata));

  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic hw(input logic [15:0] a, input logic [7:0] d);
    i_io_host_model.io_write(a, d, fwd);
  endtask

  task automatic hr(input logic [15:0] a);
    i_io_host_model.io_read(a, rdat, rval, fwd);
  endtask

  task automatic rd61(input logic [7:0] exp);
    hr(16'h0061);
    check({rval, 7'h00}, 8'h80, "61h answered");
    check(rdat, exp, "61h data");
  endtask

  // bounded wait; running out ends the run
  task automatic wait_nmi();
    int n;
    n = 0;
    while (nmi !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    check({7'h00, nmi}, 8'h01, "nmi rise");
    if (n == 20)
      print_verdict();
  endtask

  task automatic pulse_len();
    int n;
    n = 0;
    while (alt_n !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    check(8'(n), 8'(ALT), "reset pulse length");
    if (n == 100)
      print_verdict();
  endtask

  task automatic t_reset();
    rd61(8'h00);
    check({gate, spk, nmi, a20, alt_n, oe_n, irq13, 1'b0}, 8'h0c, "reset outs");
    hr(16'h0092);
    check(rdat, 8'h24, "92h default");
  endtask

  task automatic t_ctrl();
    hw(16'h0061, 8'hf3);
    rd61(8'h03);
    check({gate, spk, 6'h00}, 8'h80, "gate on, speaker low");
    cnt2 = 1'b1;
    tick(1);
    check({7'h00, spk}, 8'h01, "speaker follows");
    rd61(8'h23);
    hw(16'h0061, 8'h01);
    check({7'h00, spk}, 8'h00, "speaker gated off");
    hw(16'h0061, 8'h00);
    check({7'h00, gate}, 8'h00, "gate off");
    cnt2 = 1'b0;
  endtask

  task automatic t_refresh();
    refr = 1'b1;
    tick(1);
    refr = 1'b0;
    rd61(8'h10);
    refr = 1'b1;
    tick(1);
    refr = 1'b0;
    rd61(8'h00);
  endtask

  task automatic t_serr();
    hw(16'h0070, 8'h15);
    check({fwd, cidx}, 8'h95, "70h forward, index");
    check({7'h00, nmi}, 8'h00, "no source");
    serr_n = 1'b0;
    tick(3);
    serr_n = 1'b1;
    wait_nmi();
    rd61(8'h80);
    hw(16'h0070, 8'h95);
    check({nmi, cidx}, 8'h15, "masked");
    hw(16'h0070, 8'h15);
    check({7'h00, nmi}, 8'h01, "unmasked");
    hw(16'h0061, 8'h04);
    // status clears one edge after the disable bit lands
    tick(1);
    check({7'h00, nmi}, 8'h00, "serr disabled");
    serr_n = 1'b0;
    tick(3);
    serr_n = 1'b1;
    tick(6);
    rd61(8'h04);
    hw(16'h0061, 8'h00);
    rd61(8'h00);
    hr(16'h0070);
    check({fwd, rval, 6'h00}, 8'h80, "70h read");
  endtask

  task automatic t_iochk();
    iochk_n = 1'b0;
    wait_nmi();
    rd61(8'h40);
    hw(16'h0061, 8'h08);
    tick(1);
    check({7'h00, nmi}, 8'h00, "iochk disabled");
    rd61(8'h08);
    iochk_n = 1'b1;
    tick(4);
    hw(16'h0061, 8'h00);
    rd61(8'h00);
    hw(16'h0070, 8'h80);
  endtask

  task automatic t_fast();
    hw(16'h0092, 8'h02);
    check({fwd, a20, alt_n, 5'h00}, 8'he0, "a20 high");
    hr(16'h0092);
    check(rdat, 8'h26, "92h readback");
    hw(16'h0092, 8'h03);
    pulse_len();
    hw(16'h0092, 8'h03);
    tick(2);
    check({7'h00, alt_n}, 8'h01, "no re-arm, no pulse");
    hr(16'h0092);
    check(rdat, 8'h27, "92h bit0 kept");
    hw(16'h0092, 8'h02);
    hw(16'h0092, 8'h01);
    pulse_len();
    check({7'h00, a20}, 8'h00, "a20 low");
    fast_en = 1'b0;
    hw(16'h0092, 8'h02);
    check({fwd, a20, 6'h00}, 8'h00, "disabled write");
    hr(16'h0092);
    check({fwd, rval, 6'h00}, 8'h00, "disabled read");
    fast_en = 1'b1;
  endtask

  task automatic t_floppy();
    dack2_n = 1'b0;
    tick(3);
    check({7'h00, oe_n}, 8'h01, "dack2 blocked");
    hw(16'h03f2, 8'h08);
    tick(1);
    check({fwd, oe_n, 6'h00}, 8'h80, "dack2 enables");
    hw(16'h0372, 8'h00);
    tick(1);
    check({7'h00, oe_n}, 8'h01, "secondary clears");
    hw(16'h0372, 8'h08);
    dack2_n = 1'b1;
    tick(3);
    check({7'h00, oe_n}, 8'h01, "no dack2");
    hw(16'h03f2, 8'h00);
  endtask

  task automatic t_mouse();
    mouse_en = 1'b1;
    tick(1);
    mouse_in = 1'b1;
    tick(4);
    check({7'h00, irq13}, 8'h01, "mouse routed");
    hr(16'h0060);
    tick(1);
    check({fwd, rval, irq13, 5'h00}, 8'h80, "60h release");
    mouse_in = 1'b0;
    mouse_en = 1'b0;
    tick(2);
    mouse_in = 1'b1;
    tick(4);
    hr(16'h0060);
    check({fwd, irq13, 6'h00}, 8'h80, "function off");
    mouse_in = 1'b0;
  endtask

  initial
  begin
    repeat (100000) @(posedge clock_i);
    bad_count++;
    $display("BAD %0t run too long", $time);
    print_verdict();
  end

  initial
  begin
    repeat (10) @(posedge clock_i);
    #1;
    rst_b_i = 1'b1;
    t_reset();
    t_ctrl();
    t_refresh();
    t_serr();
    t_iochk();
    t_fast();
    t_floppy();
    t_mouse();
    print_verdict();
  end
endmodule
`default_nettype wire
